//--- rtl/pwm_pkg.sv
/*
 * Constants, register map, field positions, mode codes and carrier types
 * for the five-channel PWM generator with descriptor queue.
 * Assumes a byte-wide register port and a byte-wide DMA write stream.
 */
//
// Contract
// - Channel 0 mode from 4-bit mode code.
// - Channels 1-4 are continuous only.
// - Continuous frames repeat; disable drops output now.
// - Continuous: new compare/period at next frame.
// - Frame end sets flag; mask gates interrupt.
// - Counting mode emits group-count frames.
// - Counting group end disables, sets group flag.
// - IR mode repeats groups, flags frames, groups.
// - IR mode: new values at next group.
// - IR to counting finishes group, then stops.
// - IR mode disable drops output immediately.
// - Descriptor low fourteen bits: frame count.
// - Descriptor bit 14 picks alternate compare/period.
// - Descriptor bit 15: carrier or low.
// - Descriptor bytes pushed through entry window.
// - Eight-byte queue; status shows empty, full, count.
// - Descriptors play in order; appends allowed.
// - Queue drained: disable, stop flag, interrupt.
// - Flush bit discards queued descriptors.
// - Mode 1111 fills queue from DMA.
// - DMA start sets channel 0 enable.
// - Frame high until compare, low until period.
// - Enable bits: 4:1 main, 0 channel zero.
// - Tick rate is clock over divider plus one.

package pwm_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [11:0] ADDR_EN_MAIN = 12'h780;
	localparam logic [11:0] ADDR_EN_CH0 = 12'h781;
	localparam logic [11:0] ADDR_CLKDIV = 12'h782;
	localparam logic [11:0] ADDR_MODE = 12'h783;
	localparam logic [11:0] ADDR_CMP_BASE = 12'h794;
	localparam logic [11:0] ADDR_PER_BASE = 12'h796;
	localparam logic [11:0] CH_STRIDE = 12'h004;
	localparam logic [11:0] ADDR_GROUP_LO = 12'h7AC;
	localparam logic [11:0] ADDR_GROUP_HI = 12'h7AD;
	localparam logic [11:0] ADDR_MASK_MAIN = 12'h7B0;
	localparam logic [11:0] ADDR_FLAGS_MAIN = 12'h7B1;
	localparam logic [11:0] ADDR_MASK_FIFO = 12'h7B2;
	localparam logic [11:0] ADDR_FLAGS_FIFO = 12'h7B3;
	localparam logic [11:0] ADDR_ALT_CMP_LO = 12'h7C4;
	localparam logic [11:0] ADDR_ALT_CMP_HI = 12'h7C5;
	localparam logic [11:0] ADDR_ALT_PER_LO = 12'h7C6;
	localparam logic [11:0] ADDR_ALT_PER_HI = 12'h7C7;
	localparam logic [11:0] ADDR_WINDOW_FIRST = 12'h7C8;
	localparam logic [11:0] ADDR_WINDOW_LAST = 12'h7CB;
	localparam logic [11:0] ADDR_QUEUE_STATUS = 12'h7CD;
	localparam logic [11:0] ADDR_QUEUE_FLUSH = 12'h7CE;

	// ****************************************************************
	// Fields, codes and reset values
	// ****************************************************************
	localparam int NUM_CH = 5;
	localparam int FLAG_GROUP_BIT = 0;
	localparam int FLAG_FRAME_BASE = 2;
	localparam int FLAG_STOP_BIT = 0;
	localparam int FLUSH_BIT = 0;
	localparam int EN0_BIT = 0;
	localparam int DESC_COUNT_MSB = 13;
	localparam int DESC_ALT_BIT = 14;
	localparam int DESC_CARRIER_BIT = 15;
	localparam int QSTAT_EMPTY_BIT = 4;
	localparam int QSTAT_FULL_BIT = 5;
	localparam int QUEUE_BYTES = 8;
	localparam int DESC_BYTES = 2;

	localparam logic [3:0] MODE_COUNTING = 4'h1;
	localparam logic [3:0] MODE_IR = 4'h3;
	localparam logic [3:0] MODE_IR_FIFO = 4'h7;
	localparam logic [3:0] MODE_IR_DMA_FIFO = 4'hF;

	localparam logic [15:0] ALT_CMP_RESET = 16'h5555;
	localparam logic [15:0] ALT_PER_RESET = 16'h0000;
	localparam logic [15:0] CMP_RESET = 16'h0000;
	localparam logic [15:0] PER_RESET = 16'h0000;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	// ****************************************************************
	// Carrier types and channel 0 states
	// ****************************************************************
	typedef struct packed {
		logic [11:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} dma_byte_t;

	typedef enum logic [1:0] {
		C0_IDLE = 2'b01,
		C0_RUN = 2'b10
	} ch0_state_t;

endpackage

//--- rtl/pwm_modes_ir_fifo.sv
/*
 * Five-channel PWM generator; channel 0 adds counting, IR, IR queue and
 * DMA-fed IR queue modes driven by 16-bit burst descriptors.
 * Assumes synchronous inputs on clk, a byte-wide register port with read
 * data one cycle after the read strobe, and a DMA source that stops
 * offering bytes while dma_ready is low.
 */
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps

module pwm_modes_ir_fifo #(
	parameter int QUEUE_BYTES = pwm_pkg::QUEUE_BYTES
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire pwm_pkg::bus_req_t bus,
	output logic [7:0] rdata,
	input wire pwm_pkg::dma_byte_t dma,
	output logic dma_ready,
	input wire logic dma_start,
	output logic [4:0] pwm_out,
	output logic irq
);

	// ****************************************************************
	// State
	// ****************************************************************
	localparam int PW = $clog2(QUEUE_BYTES);
	localparam int CW = PW + 1;
	localparam logic [CW-1:0] Q_FULL = CW'(QUEUE_BYTES);
	localparam logic [CW-1:0] Q_DESC = CW'(pwm_pkg::DESC_BYTES);

	typedef struct packed {
		logic [4:0] en;
		logic [7:0] clkdiv;
		logic [7:0] mode;
		logic [4:0][15:0] cmp;
		logic [4:0][15:0] per;
		logic [15:0] pnum;
		logic [7:0] mask0;
		logic [7:0] flags0;
		logic [7:0] mask1;
		logic [7:0] flags1;
		logic [15:0] acmp;
		logic [15:0] aper;
		logic [QUEUE_BYTES-1:0][7:0] mem;
		logic [PW-1:0] wptr;
		logic [PW-1:0] rptr;
		logic [CW-1:0] qcount;
		logic [7:0] div_cnt;
		logic tick;
		logic [4:0] started;
		logic [4:0][15:0] cnt;
		logic [4:0][15:0] lcmp;
		logic [4:0][15:0] lper;
		logic [15:0] gleft;
		logic carrier;
		pwm_pkg::ch0_state_t c0;
		logic [7:0] rdata;
		logic [4:0] out;
	} state_t;

	state_t s_reg;
	state_t s_next;

	logic [3:0] mode_code;
	logic is_group;
	logic is_queue;
	logic q_full;
	logic q_has_desc;
	logic [15:0] desc;
	logic [PW-1:0] rptr_hi;
	logic q_empty;
	logic irq_main;
	logic irq_fifo;

	assign mode_code = s_reg.mode[3:0];
	// Any code outside the four listed ones falls back to continuous.
	assign is_group = (mode_code == pwm_pkg::MODE_COUNTING) ||
		(mode_code == pwm_pkg::MODE_IR);
	assign is_queue = (mode_code == pwm_pkg::MODE_IR_FIFO) ||
		(mode_code == pwm_pkg::MODE_IR_DMA_FIFO);
	assign q_full = (s_reg.qcount == Q_FULL);
	assign q_has_desc = (s_reg.qcount >= Q_DESC);
	assign q_empty = (s_reg.qcount == '0);
	assign rptr_hi = s_reg.rptr + PW'(1);
	assign desc = {s_reg.mem[rptr_hi], s_reg.mem[s_reg.rptr]};
	// DMA is held off while the queue is full, so no DMA byte is lost.
	assign dma_ready = !q_full &&
		(mode_code == pwm_pkg::MODE_IR_DMA_FIFO);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		logic [7:0] fset0;
		logic [7:0] fset1;
		logic [7:0] clr0;
		logic [7:0] clr1;
		logic push;
		logic [7:0] push_byte;
		logic pop;
		logic load_primary;
		logic flush;
		logic [11:0] ch_off;
		s_next = s_reg;
		fset0 = 8'h00;
		fset1 = 8'h00;
		clr0 = 8'h00;
		clr1 = 8'h00;
		push = 1'b0;
		push_byte = 8'h00;
		pop = 1'b0;
		load_primary = 1'b0;
		flush = 1'b0;
		ch_off = 12'h000;

		// Divider: one tick every clkdiv+1 clocks.
		// The divider runs free, so a new frame may wait up to clkdiv clocks.
		s_next.tick = 1'b0;
		if (s_reg.div_cnt >= s_reg.clkdiv) begin
			s_next.div_cnt = 8'h00;
			s_next.tick = 1'b1;
		end else begin
			s_next.div_cnt = s_reg.div_cnt + 8'h01;
		end

		// Register writes.
		if (bus.wr) begin
			case (bus.addr)
				pwm_pkg::ADDR_EN_MAIN: s_next.en[4:1] = bus.wdata[4:1];
				pwm_pkg::ADDR_EN_CH0: s_next.en[0] = bus.wdata[pwm_pkg::EN0_BIT];
				pwm_pkg::ADDR_CLKDIV: s_next.clkdiv = bus.wdata;
				pwm_pkg::ADDR_MODE: s_next.mode = bus.wdata;
				pwm_pkg::ADDR_GROUP_LO: s_next.pnum[7:0] = bus.wdata;
				pwm_pkg::ADDR_GROUP_HI: s_next.pnum[15:8] = bus.wdata;
				pwm_pkg::ADDR_MASK_MAIN: s_next.mask0 = bus.wdata;
				pwm_pkg::ADDR_FLAGS_MAIN: clr0 = bus.wdata;
				pwm_pkg::ADDR_MASK_FIFO: s_next.mask1 = bus.wdata;
				pwm_pkg::ADDR_FLAGS_FIFO: clr1 = bus.wdata;
				pwm_pkg::ADDR_ALT_CMP_LO: s_next.acmp[7:0] = bus.wdata;
				pwm_pkg::ADDR_ALT_CMP_HI: s_next.acmp[15:8] = bus.wdata;
				pwm_pkg::ADDR_ALT_PER_LO: s_next.aper[7:0] = bus.wdata;
				pwm_pkg::ADDR_ALT_PER_HI: s_next.aper[15:8] = bus.wdata;
				pwm_pkg::ADDR_QUEUE_FLUSH: flush = bus.wdata[pwm_pkg::FLUSH_BIT];
				default: ;
			endcase
			for (int ch = 0; ch < pwm_pkg::NUM_CH; ch++) begin
				ch_off = pwm_pkg::CH_STRIDE * 12'(ch);
				if (bus.addr == pwm_pkg::ADDR_CMP_BASE + ch_off)
					s_next.cmp[ch][7:0] = bus.wdata;
				if (bus.addr == pwm_pkg::ADDR_CMP_BASE + ch_off + 12'h001)
					s_next.cmp[ch][15:8] = bus.wdata;
				if (bus.addr == pwm_pkg::ADDR_PER_BASE + ch_off)
					s_next.per[ch][7:0] = bus.wdata;
				if (bus.addr == pwm_pkg::ADDR_PER_BASE + ch_off + 12'h001)
					s_next.per[ch][15:8] = bus.wdata;
			end
			// Each window byte is one queue byte, so byte, half-word and
			// word sequences in ascending order all land low byte first.
			if (bus.addr >= pwm_pkg::ADDR_WINDOW_FIRST &&
				bus.addr <= pwm_pkg::ADDR_WINDOW_LAST &&
				mode_code != pwm_pkg::MODE_IR_DMA_FIFO) begin
				push = 1'b1;
				push_byte = bus.wdata;
			end
		end
		if (dma.valid && mode_code == pwm_pkg::MODE_IR_DMA_FIFO) begin
			push = 1'b1;
			push_byte = dma.data;
		end
		if (dma_start && mode_code == pwm_pkg::MODE_IR_DMA_FIFO)
			s_next.en[0] = 1'b1;

		// Channels 1-4: continuous only.
		// A disabled channel drops its frame, so enabling starts a fresh one.
		for (int ch = 1; ch < pwm_pkg::NUM_CH; ch++) begin
			if (!s_reg.en[ch]) begin
				s_next.started[ch] = 1'b0;
				s_next.cnt[ch] = 16'h0000;
			end else if (s_reg.tick) begin
				if (!s_reg.started[ch]) begin
					s_next.started[ch] = 1'b1;
					s_next.cnt[ch] = 16'h0000;
					s_next.lcmp[ch] = s_reg.cmp[ch];
					s_next.lper[ch] = s_reg.per[ch];
				end else if (s_reg.cnt[ch] + 16'h0001 >= s_reg.lper[ch]) begin
					fset0[pwm_pkg::FLAG_FRAME_BASE + ch] = 1'b1;
					s_next.cnt[ch] = 16'h0000;
					s_next.lcmp[ch] = s_reg.cmp[ch];
					s_next.lper[ch] = s_reg.per[ch];
				end else begin
					s_next.cnt[ch] = s_reg.cnt[ch] + 16'h0001;
				end
			end
		end

		// Channel 0 sequencer.
		case (s_reg.c0)
			pwm_pkg::C0_IDLE: begin
				s_next.started[0] = 1'b0;
				if (s_reg.en[0] && s_reg.tick) begin
					s_next.cnt[0] = 16'h0000;
					// Too few queued bytes for a descriptor stops the channel.
					if (is_queue) begin
						if (q_has_desc) begin
							pop = 1'b1;
							s_next.started[0] = 1'b1;
							s_next.c0 = pwm_pkg::C0_RUN;
						end else begin
							s_next.en[0] = 1'b0;
							fset1[pwm_pkg::FLAG_STOP_BIT] = 1'b1;
						end
					end else begin
						load_primary = 1'b1;
						s_next.started[0] = 1'b1;
						s_next.c0 = pwm_pkg::C0_RUN;
					end
				end
			end
			pwm_pkg::C0_RUN: begin
				if (!s_reg.en[0]) begin
					s_next.c0 = pwm_pkg::C0_IDLE;
					s_next.started[0] = 1'b0;
				end else if (s_reg.tick) begin
					if (s_reg.cnt[0] + 16'h0001 >= s_reg.lper[0]) begin
						fset0[pwm_pkg::FLAG_FRAME_BASE] = 1'b1;
						s_next.cnt[0] = 16'h0000;
						if (!is_group && !is_queue) begin
							load_primary = 1'b1;
						end else if (s_reg.gleft > 16'h0001) begin
							s_next.gleft = s_reg.gleft - 16'h0001;
						end else if (is_group) begin
							// The mode is read at group end, so a switch
							// from IR to counting ends the group cleanly.
							fset0[pwm_pkg::FLAG_GROUP_BIT] = 1'b1;
							if (mode_code == pwm_pkg::MODE_COUNTING) begin
								s_next.en[0] = 1'b0;
								s_next.started[0] = 1'b0;
								s_next.c0 = pwm_pkg::C0_IDLE;
							end else begin
								load_primary = 1'b1;
							end
						end else if (q_has_desc) begin
							pop = 1'b1;
						end else begin
							s_next.en[0] = 1'b0;
							fset1[pwm_pkg::FLAG_STOP_BIT] = 1'b1;
							s_next.started[0] = 1'b0;
							s_next.c0 = pwm_pkg::C0_IDLE;
						end
					end else begin
						s_next.cnt[0] = s_reg.cnt[0] + 16'h0001;
					end
				end
			end
			default: begin
				s_next.c0 = pwm_pkg::C0_IDLE;
				s_next.started[0] = 1'b0;
			end
		endcase

		// Group or frame parameters taken from the primary registers.
		if (load_primary) begin
			s_next.lcmp[0] = s_reg.cmp[0];
			s_next.lper[0] = s_reg.per[0];
			s_next.gleft = s_reg.pnum;
			s_next.carrier = 1'b1;
		end
		// A zero frame count still plays one frame, since the group ends
		// on the frame that leaves one or fewer remaining.
		if (pop) begin
			s_next.gleft = {2'b00, desc[pwm_pkg::DESC_COUNT_MSB:0]};
			s_next.lcmp[0] = desc[pwm_pkg::DESC_ALT_BIT] ?
				s_reg.acmp : s_reg.cmp[0];
			s_next.lper[0] = desc[pwm_pkg::DESC_ALT_BIT] ?
				s_reg.aper : s_reg.per[0];
			s_next.carrier = desc[pwm_pkg::DESC_CARRIER_BIT];
		end

		// Queue pointers; a push into a full queue is dropped.
		// A lone byte waits in the queue for its partner, since a
		// descriptor is popped only when both of its bytes are present.
		if (push && q_full)
			push = 1'b0;
		if (push)
			s_next.mem[s_reg.wptr] = push_byte;
		s_next.wptr = s_reg.wptr + PW'(push);
		s_next.rptr = s_reg.rptr + (pop ? PW'(pwm_pkg::DESC_BYTES) : PW'(0));
		s_next.qcount = s_reg.qcount + CW'(push) - (pop ? Q_DESC : CW'(0));
		// Flushing mid-transmission is not supported; it simply wins.
		if (flush) begin
			s_next.wptr = '0;
			s_next.rptr = '0;
			s_next.qcount = '0;
		end

		// Sticky flags: a new event beats a same-cycle clear.
		s_next.flags0 = (s_reg.flags0 & ~clr0) | fset0;
		s_next.flags1 = (s_reg.flags1 & ~clr1) | fset1;

		// Outputs high in the count phase, low in the remaining phase.
		// They come from the next state, so a pin moves with its counter.
		for (int ch = 0; ch < pwm_pkg::NUM_CH; ch++) begin
			s_next.out[ch] = s_next.started[ch] &&
				(s_next.cnt[ch] < s_next.lcmp[ch]);
		end
		s_next.out[0] = s_next.out[0] && s_next.carrier;

		// Read data, valid only in the cycle after the strobe.
		s_next.rdata = 8'h00;
		if (bus.rd) begin
			case (bus.addr)
				pwm_pkg::ADDR_EN_MAIN: s_next.rdata = {3'b000, s_reg.en[4:1], 1'b0};
				pwm_pkg::ADDR_EN_CH0: s_next.rdata = {7'h00, s_reg.en[0]};
				pwm_pkg::ADDR_CLKDIV: s_next.rdata = s_reg.clkdiv;
				pwm_pkg::ADDR_MODE: s_next.rdata = s_reg.mode;
				pwm_pkg::ADDR_GROUP_LO: s_next.rdata = s_reg.pnum[7:0];
				pwm_pkg::ADDR_GROUP_HI: s_next.rdata = s_reg.pnum[15:8];
				pwm_pkg::ADDR_MASK_MAIN: s_next.rdata = s_reg.mask0;
				pwm_pkg::ADDR_FLAGS_MAIN: s_next.rdata = s_reg.flags0;
				pwm_pkg::ADDR_MASK_FIFO: s_next.rdata = s_reg.mask1;
				pwm_pkg::ADDR_FLAGS_FIFO: s_next.rdata = s_reg.flags1;
				pwm_pkg::ADDR_ALT_CMP_LO: s_next.rdata = s_reg.acmp[7:0];
				pwm_pkg::ADDR_ALT_CMP_HI: s_next.rdata = s_reg.acmp[15:8];
				pwm_pkg::ADDR_ALT_PER_LO: s_next.rdata = s_reg.aper[7:0];
				pwm_pkg::ADDR_ALT_PER_HI: s_next.rdata = s_reg.aper[15:8];
				pwm_pkg::ADDR_QUEUE_STATUS: begin
					s_next.rdata = 8'h00;
					s_next.rdata[3:0] = 4'(s_reg.qcount);
					s_next.rdata[pwm_pkg::QSTAT_EMPTY_BIT] = q_empty;
					s_next.rdata[pwm_pkg::QSTAT_FULL_BIT] = q_full;
				end
				default: s_next.rdata = 8'h00;
			endcase
			for (int ch = 0; ch < pwm_pkg::NUM_CH; ch++) begin
				ch_off = pwm_pkg::CH_STRIDE * 12'(ch);
				if (bus.addr == pwm_pkg::ADDR_CMP_BASE + ch_off)
					s_next.rdata = s_reg.cmp[ch][7:0];
				if (bus.addr == pwm_pkg::ADDR_CMP_BASE + ch_off + 12'h001)
					s_next.rdata = s_reg.cmp[ch][15:8];
				if (bus.addr == pwm_pkg::ADDR_PER_BASE + ch_off)
					s_next.rdata = s_reg.per[ch][7:0];
				if (bus.addr == pwm_pkg::ADDR_PER_BASE + ch_off + 12'h001)
					s_next.rdata = s_reg.per[ch][15:8];
			end
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_reg <= '0;
			s_reg.cmp <= {pwm_pkg::NUM_CH{pwm_pkg::CMP_RESET}};
			s_reg.per <= {pwm_pkg::NUM_CH{pwm_pkg::PER_RESET}};
			s_reg.acmp <= pwm_pkg::ALT_CMP_RESET;
			s_reg.aper <= pwm_pkg::ALT_PER_RESET;
			s_reg.mode <= pwm_pkg::BYTE_RESET;
			s_reg.c0 <= pwm_pkg::C0_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	assign rdata = s_reg.rdata;
	assign pwm_out = s_reg.out;
	// Interrupt mirrors flags through masks; the chip-level enable is outside.
	assign irq_main = |(s_reg.flags0 & s_reg.mask0);
	assign irq_fifo = |(s_reg.flags1 & s_reg.mask1);
	assign irq = irq_main || irq_fifo;

endmodule // pwm_modes_ir_fifo

//--- dv/pwm_chk.sv
/*
 * Port checker for the PWM block, bound to its top module.
 * Assumes one clock domain and the byte-wide register port.
 */
`timescale 1ns/100ps

module pwm_chk #(
	parameter int QUEUE_BYTES = 8
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire pwm_pkg::bus_req_t bus,
	input wire logic [7:0] rdata,
	input wire pwm_pkg::dma_byte_t dma,
	input wire logic dma_ready,
	input wire logic dma_start,
	input wire logic [4:0] pwm_out,
	input wire logic irq
);
	localparam logic [3:0] DEPTH = 4'(QUEUE_BYTES);
	logic [3:0] mode_reg;
	logic [7:0] mask_main_reg;
	logic [7:0] mask_fifo_reg;
	logic [4:1] en_main_reg;

	// ****
	// Register shadows
	// ****
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mode_reg <= 4'h0;
			mask_main_reg <= 8'h00;
			mask_fifo_reg <= 8'h00;
			en_main_reg <= 4'h0;
		end else if (bus.wr) begin
			case (bus.addr)
				pwm_pkg::ADDR_MODE: mode_reg <= bus.wdata[3:0];
				pwm_pkg::ADDR_MASK_MAIN: mask_main_reg <= bus.wdata;
				pwm_pkg::ADDR_MASK_FIFO: mask_fifo_reg <= bus.wdata;
				pwm_pkg::ADDR_EN_MAIN: en_main_reg <= bus.wdata[4:1];
				default: ;
			endcase
		end
	end

	// ****
	// Properties
	// ****
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_flush;
		bus.wr && bus.addr == pwm_pkg::ADDR_QUEUE_FLUSH && bus.wdata[0];
	endsequence
	sequence s_stat_rd;
		bus.rd && bus.addr == pwm_pkg::ADDR_QUEUE_STATUS;
	endsequence
	sequence s_ch0_clr;
		bus.wr && bus.addr == pwm_pkg::ADDR_EN_CH0 && !bus.wdata[0]
			##1 !dma_start;
	endsequence

	property p_ch0_off;
		(mode_reg != pwm_pkg::MODE_IR) ##0 s_ch0_clr |-> ##1 !pwm_out[0];
	endproperty
	a_ch0_off: assert property (p_ch0_off)
		else $error("ch0 still high after disable");
	property p_ir_off;
		(mode_reg == pwm_pkg::MODE_IR) ##0 s_ch0_clr |-> ##1 !pwm_out[0] [*2];
	endproperty
	a_ir_off: assert property (p_ir_off)
		else $error("ch0 group not abandoned on disable");
	property p_main_off;
		(pwm_out[4:1] & ~en_main_reg & ~$past(en_main_reg)) == 4'h0;
	endproperty
	a_main_off: assert property (p_main_off)
		else $error("disabled channel drives high");
	property p_irq_masked;
		mask_main_reg == 8'h00 && mask_fifo_reg == 8'h00 |-> !irq;
	endproperty
	a_irq_masked: assert property (p_irq_masked)
		else $error("irq with all masks clear");
	property p_dma_mode;
		mode_reg != pwm_pkg::MODE_IR_DMA_FIFO |-> !dma_ready;
	endproperty
	a_dma_mode: assert property (p_dma_mode)
		else $error("dma_ready outside DMA queue mode");
	property p_stat_form;
		s_stat_rd |=> rdata[4] == (rdata[3:0] == 4'h0) && rdata[7:6] == 2'b00;
	endproperty
	a_stat_form: assert property (p_stat_form)
		else $error("status empty flag disagrees with count");
	property p_stat_depth;
		s_stat_rd |=> rdata[3:0] <= DEPTH && rdata[5] == (rdata[3:0] == DEPTH);
	endproperty
	a_stat_depth: assert property (p_stat_depth)
		else $error("status count or full flag wrong");
	property p_flush;
		s_flush ##1 (!bus.wr && !dma.valid) ##1 s_stat_rd |=> rdata == 8'h10;
	endproperty
	a_flush: assert property (p_flush)
		else $error("queue not empty after flush");
endmodule // pwm_chk

bind pwm_modes_ir_fifo pwm_chk #(.QUEUE_BYTES(QUEUE_BYTES)) i_pwm_chk (
	.clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata), .dma(dma),
	.dma_ready(dma_ready), .dma_start(dma_start), .pwm_out(pwm_out),
	.irq(irq));

//--- dv/pwm_load.sv
/*
 * Load model for one PWM output: counts pulses, keeps last high width.
 * Assumes the output is sampled on the block's own clock.
 */
`timescale 1ns/100ps

module pwm_load (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic pwm,
	input wire logic clr,
	output logic [15:0] pulses,
	output logic [15:0] hi_run
);
	logic [15:0] run;
	logic prev;

	// Widths are in clocks, so a divided tick shows as a longer run.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pulses <= 16'h0000;
			hi_run <= 16'h0000;
			run <= 16'h0000;
			prev <= 1'b0;
		end else begin
			prev <= pwm;
			run <= pwm ? run + 16'h0001 : 16'h0000;
			if (clr)
				pulses <= 16'h0000;
			else if (pwm && !prev)
				pulses <= pulses + 16'h0001;
			if (prev && !pwm)
				hi_run <= run;
		end
	end
endmodule // pwm_load

//--- dv/tb_top.sv
/*
 * Self-checking bench for the PWM block with two load models.
 * Assumes the checker is bound by its own file.
 */
`timescale 1ns/100ps

module tb_top;
	logic clk;
	logic reset_n;
	pwm_pkg::bus_req_t bus;
	logic [7:0] rdata;
	pwm_pkg::dma_byte_t dma;
	logic dma_ready;
	logic dma_start;
	logic [4:0] pwm_out;
	logic irq;
	logic clr;
	logic [15:0] p0;
	logic [15:0] h0;
	logic [15:0] p1;
	logic [15:0] h1;
	logic [7:0] d;
	int num_errors;
	int cmp_count;
	logic [7:0] d_seq [6] = '{8'h03, 8'h80, 8'h02, 8'hC0, 8'h02, 8'h00};
	logic [7:0] d_dma [4] = '{8'h02, 8'h80, 8'h01, 8'h80};

	pwm_modes_ir_fifo #(.QUEUE_BYTES(8)) i_pwm_modes_ir_fifo (.clk(clk),
		.reset_n(reset_n), .bus(bus), .rdata(rdata), .dma(dma),
		.dma_ready(dma_ready), .dma_start(dma_start), .pwm_out(pwm_out),
		.irq(irq));
	pwm_load i_pwm_load0 (.clk(clk), .reset_n(reset_n), .pwm(pwm_out[0]),
		.clr(clr), .pulses(p0), .hi_run(h0));
	pwm_load i_pwm_load1 (.clk(clk), .reset_n(reset_n), .pwm(pwm_out[1]),
		.clr(clr), .pulses(p1), .hi_run(h1));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ****
	// Bus and check tasks
	// ****
	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		@(posedge clk);
		bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask
	task automatic w16(input logic [11:0] a, input logic [15:0] v);
		wr(a, v[7:0]);
		wr(a + 12'h001, v[15:8]);
	endtask
	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rchk(input logic [11:0] a, input logic [7:0] e);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		@(negedge clk);
		d = rdata;
		chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, d});
	endtask
	task automatic tk(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic restart;
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		tk(6000);
		num_errors++;
		$display("BAD watchdog expected finish seen hang");
		summarize();
	end

	// ****
	// Tests
	// ****
	initial begin
		bus = '0;
		dma = '0;
		dma_start = 1'b0;
		clr = 1'b0;
		reset_n = 1'b0;
		num_errors = 0;
		cmp_count = 0;
		tk(5);
		reset_n <= 1'b1;
		rchk(pwm_pkg::ADDR_QUEUE_STATUS, 8'h10);
		rchk(pwm_pkg::ADDR_ALT_CMP_HI, 8'h55);
		rchk(pwm_pkg::ADDR_EN_CH0, 8'h00);
		rchk(12'h7CF, 8'h00);
		$display("test reset done");
		w16(pwm_pkg::ADDR_CMP_BASE, 16'h0002);
		w16(pwm_pkg::ADDR_PER_BASE, 16'h0005);
		wr(pwm_pkg::ADDR_MASK_MAIN, 8'h04);
		wr(pwm_pkg::ADDR_EN_CH0, 8'h01);
		tk(30);
		chk("ch0 high run", 16'h0002, h0);
		chk("frame irq", 16'h0001, irq);
		w16(pwm_pkg::ADDR_CMP_BASE, 16'h0003);
		tk(30);
		chk("new high run", 16'h0003, h0);
		wr(pwm_pkg::ADDR_CLKDIV, 8'h01);
		tk(60);
		chk("divided run", 16'h0006, h0);
		wr(pwm_pkg::ADDR_CLKDIV, 8'h00);
		wr(pwm_pkg::ADDR_EN_CH0, 8'h00);
		wr(pwm_pkg::ADDR_FLAGS_MAIN, 8'h04);
		tk(2);
		chk("irq cleared", 16'h0000, irq);
		$display("test continuous done");
		wr(pwm_pkg::ADDR_MODE, {4'h0, pwm_pkg::MODE_COUNTING});
		w16(pwm_pkg::ADDR_CMP_BASE + pwm_pkg::CH_STRIDE, 16'h0001);
		w16(pwm_pkg::ADDR_PER_BASE + pwm_pkg::CH_STRIDE, 16'h0003);
		restart();
		wr(pwm_pkg::ADDR_EN_MAIN, 8'h02);
		tk(40);
		chk("ch1 keeps running", 16'h0001, p1 > 16'h0008);
		chk("ch1 high run", 16'h0001, h1);
		wr(pwm_pkg::ADDR_EN_MAIN, 8'h00);
		w16(pwm_pkg::ADDR_CMP_BASE, 16'h0001);
		w16(pwm_pkg::ADDR_PER_BASE, 16'h0003);
		w16(pwm_pkg::ADDR_GROUP_LO, 16'h0004);
		wr(pwm_pkg::ADDR_FLAGS_MAIN, 8'hFF);
		restart();
		wr(pwm_pkg::ADDR_EN_CH0, 8'h01);
		tk(40);
		chk("group pulses", 16'h0004, p0);
		rchk(pwm_pkg::ADDR_EN_CH0, 8'h00);
		rchk(pwm_pkg::ADDR_FLAGS_MAIN, 8'h05);
		$display("test counting done");
		w16(pwm_pkg::ADDR_GROUP_LO, 16'h0003);
		wr(pwm_pkg::ADDR_MODE, {4'h0, pwm_pkg::MODE_IR});
		restart();
		wr(pwm_pkg::ADDR_EN_CH0, 8'h01);
		tk(50);
		wr(pwm_pkg::ADDR_MODE, {4'h0, pwm_pkg::MODE_COUNTING});
		tk(40);
		chk("groups repeat", 16'h0001, p0 > 16'h0006);
		chk("whole groups", 16'h0000, p0 % 16'h0003);
		rchk(pwm_pkg::ADDR_EN_CH0, 8'h00);
		wr(pwm_pkg::ADDR_MODE, {4'h0, pwm_pkg::MODE_IR});
		wr(pwm_pkg::ADDR_EN_CH0, 8'h01);
		tk(20);
		wr(pwm_pkg::ADDR_EN_CH0, 8'h00);
		tk(3);
		chk("ir stop", 16'h0000, pwm_out[0]);
		$display("test ir done");
		wr(pwm_pkg::ADDR_MODE, {4'h0, pwm_pkg::MODE_IR_FIFO});
		wr(pwm_pkg::ADDR_QUEUE_FLUSH, 8'h01);
		w16(pwm_pkg::ADDR_ALT_CMP_LO, 16'h0002);
		w16(pwm_pkg::ADDR_ALT_PER_LO, 16'h0004);
		foreach (d_seq[i])
			wr(pwm_pkg::ADDR_WINDOW_FIRST + 12'(i % 4), d_seq[i]);
		rchk(pwm_pkg::ADDR_QUEUE_STATUS, 8'h06);
		wr(pwm_pkg::ADDR_FLAGS_FIFO, 8'h01);
		wr(pwm_pkg::ADDR_MASK_MAIN, 8'h00);
		wr(pwm_pkg::ADDR_MASK_FIFO, 8'h01);
		restart();
		wr(pwm_pkg::ADDR_EN_CH0, 8'h01);
		tk(60);
		chk("queue pulses", 16'h0005, p0);
		chk("alt last", 16'h0002, h0);
		rchk(pwm_pkg::ADDR_EN_CH0, 8'h00);
		rchk(pwm_pkg::ADDR_FLAGS_FIFO, 8'h01);
		chk("stop irq", 16'h0001, irq);
		wr(pwm_pkg::ADDR_FLAGS_FIFO, 8'h01);
		tk(2);
		chk("stop irq cleared", 16'h0000, irq);
		for (int i = 0; i < 10; i++)
			wr(pwm_pkg::ADDR_WINDOW_FIRST + 12'(i % 4), 8'h01);
		rchk(pwm_pkg::ADDR_QUEUE_STATUS, 8'h28);
		wr(pwm_pkg::ADDR_QUEUE_FLUSH, 8'h01);
		rchk(pwm_pkg::ADDR_QUEUE_STATUS, 8'h10);
		$display("test queue done");
		wr(pwm_pkg::ADDR_MODE, {4'h0, pwm_pkg::MODE_IR_DMA_FIFO});
		wr(pwm_pkg::ADDR_WINDOW_FIRST, 8'h07);
		rchk(pwm_pkg::ADDR_QUEUE_STATUS, 8'h10);
		chk("dma ready", 16'h0001, dma_ready);
		foreach (d_dma[i]) begin
			@(posedge clk);
			dma <= '{valid: 1'b1, data: d_dma[i]};
			@(posedge clk);
			dma <= '0;
		end
		restart();
		@(posedge clk);
		dma_start <= 1'b1;
		@(posedge clk);
		dma_start <= 1'b0;
		tk(40);
		chk("dma pulses", 16'h0003, p0);
		rchk(pwm_pkg::ADDR_EN_CH0, 8'h00);
		$display("test dma done");
		summarize();
	end
endmodule // tb_top
